//--- rtl/ppmc_pkg.sv
package ppmc_pkg;
    // configuration dword offsets
    localparam logic [7:0] PPMC_OFF_CAP = 8'h78;
    localparam logic [7:0] PPMC_OFF_CAP_PTR = 8'h34;
    localparam int PPMC_CAP_PTR_LANE = 0;
    // field positions
    localparam int PPMC_BIT_WAKE_D3COLD = 31;
    localparam int PPMC_BIT_WAKE_D3HOT = 30;
    localparam int PPMC_BIT_WAKE_ST2 = 29;
    localparam int PPMC_BIT_WAKE_ST1 = 28;
    localparam int PPMC_BIT_WAKE_ST0 = 27;
    localparam int PPMC_BIT_ST2_SUP = 26;
    localparam int PPMC_BIT_ST1_SUP = 25;
    localparam int PPMC_AUX_LSB = 22;
    localparam int PPMC_BIT_DSI = 21;
    localparam int PPMC_BIT_CLK_WAKE = 19;
    localparam int PPMC_VER_LSB = 16;
    localparam int PPMC_NEXT_LSB = 8;
    // field values
    localparam logic [2:0] PPMC_AUX_NONE = 3'h0;
    localparam logic [2:0] PPMC_AUX_320MA = 3'h6;
    localparam logic [2:0] PPMC_VERSION = 3'h2;
    localparam logic [7:0] PPMC_NEXT_PTR = 8'h00;
    localparam logic [7:0] PPMC_CAPABILITY_IDENTIFIER = 8'h01;
    localparam logic [31:0] PPMC_RESET_DATA = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] offset;
        logic [3:0] byte_en;
    } ppmc_req_t;
endpackage : ppmc_pkg

//--- rtl/ppmc_cap_reg.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - bit 31 follows the aux supply detect pin level.
// - bits 30 and 27 always read one.
// - bits 29 and 28 always read zero.
// - bits 26 and 25 always read zero.
// - bits 24:22 read 000b with pin low, 110b with pin high.
// - bit 21 always reads zero.
// - bit 19 always reads zero.
// - bits 18:16 read constant 010b.
// - bits 15:8 read zero, no further capability.
// - bits 7:0 read capability identifier 01h.
// - register is 32 bits at configuration offset 78h.
// - capabilities pointer byte at offset 34h reads 78h.
module ppmc_cap_reg (
    input wire logic clock,
    input wire logic reset_n,
    input wire ppmc_pkg::ppmc_req_t cfg_req,
    input wire logic aux_supply_detect,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack
);
    logic aux_meta_q, aux_meta_d;
    logic aux_sync_q, aux_sync_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;

    function automatic logic [31:0] cap_word(input logic aux);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ppmc_pkg::PPMC_BIT_WAKE_D3COLD] = aux;
        w[ppmc_pkg::PPMC_BIT_WAKE_D3HOT] = 1'b1;
        w[ppmc_pkg::PPMC_BIT_WAKE_ST0] = 1'b1;
        w[ppmc_pkg::PPMC_BIT_WAKE_ST2] = 1'b0;
        w[ppmc_pkg::PPMC_BIT_WAKE_ST1] = 1'b0;
        w[ppmc_pkg::PPMC_BIT_ST2_SUP] = 1'b0;
        w[ppmc_pkg::PPMC_BIT_ST1_SUP] = 1'b0;
        w[ppmc_pkg::PPMC_AUX_LSB +: 3] = aux ? ppmc_pkg::PPMC_AUX_320MA
                                             : ppmc_pkg::PPMC_AUX_NONE;
        w[ppmc_pkg::PPMC_BIT_DSI] = 1'b0;
        w[ppmc_pkg::PPMC_BIT_CLK_WAKE] = 1'b0;
        w[ppmc_pkg::PPMC_VER_LSB +: 3] = ppmc_pkg::PPMC_VERSION;
        w[ppmc_pkg::PPMC_NEXT_LSB +: 8] = ppmc_pkg::PPMC_NEXT_PTR;
        w[7:0] = ppmc_pkg::PPMC_CAPABILITY_IDENTIFIER;
        return w;
    endfunction : cap_word

    // pin is asynchronous to the bus clock
    always_comb begin
        aux_meta_d = aux_supply_detect;
        aux_sync_d = aux_meta_q;
    end

    // reads elsewhere return zero; writes are acked but never stored
    always_comb begin
        rdata_d = ppmc_pkg::PPMC_RESET_DATA;
        ack_d = cfg_req.valid;
        if (cfg_req.valid && !cfg_req.write) begin
            if (cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP) begin
                rdata_d = cap_word(aux_sync_q);
            end else if (cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP_PTR) begin
                rdata_d[ppmc_pkg::PPMC_CAP_PTR_LANE +: 8] =
                    ppmc_pkg::PPMC_OFF_CAP;
            end
        end
    end

    // synchroniser kept apart from the bus path so each group
    // registers only its own next values
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            aux_meta_q <= 1'b0;
            aux_sync_q <= 1'b0;
        end else begin
            aux_meta_q <= aux_meta_d;
            aux_sync_q <= aux_sync_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdata_q <= ppmc_pkg::PPMC_RESET_DATA;
            ack_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    assign cfg_rdata = rdata_q;
    assign cfg_ack = ack_q;

    a_cap_fixed_bits: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP)
        |=> (cfg_rdata[30:25] == 6'h24 && cfg_rdata[21] == 1'b0
             && cfg_rdata[19:0] == 20'h20001))
        else $error("fixed capability bits wrong");

    a_aux_tracks_pin: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP)
        |=> (cfg_rdata[31] == $past(aux_sync_q)
             && cfg_rdata[24:22] == ($past(aux_sync_q) ? 3'h6 : 3'h0)))
        else $error("aux fields do not follow pin");

    a_write_acked: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && cfg_req.write) |=> (cfg_ack && cfg_rdata == 32'h0))
        else $error("write not completed cleanly");

    a_cap_pointer: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write && cfg_req.offset == 8'h34)
        |=> (cfg_ack && cfg_rdata == 32'h78))
        else $error("capability pointer wrong");

    a_wake_hot_set: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP)
        |=> (cfg_rdata[ppmc_pkg::PPMC_BIT_WAKE_D3HOT]
             && cfg_rdata[ppmc_pkg::PPMC_BIT_WAKE_ST0]))
        else $error("wake bits for full and hot states not set");

    a_wake_mid_clear: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP)
        |=> (!cfg_rdata[ppmc_pkg::PPMC_BIT_WAKE_ST2]
             && !cfg_rdata[ppmc_pkg::PPMC_BIT_WAKE_ST1]))
        else $error("wake bits for middle states not clear");

    a_mid_state_clear: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP)
        |=> (!cfg_rdata[ppmc_pkg::PPMC_BIT_ST2_SUP]
             && !cfg_rdata[ppmc_pkg::PPMC_BIT_ST1_SUP]))
        else $error("middle power states advertised");

    a_aux_current: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP)
        |=> (cfg_rdata[ppmc_pkg::PPMC_AUX_LSB +: 3] == ($past(aux_sync_q)
             ? ppmc_pkg::PPMC_AUX_320MA : ppmc_pkg::PPMC_AUX_NONE)))
        else $error("aux current field wrong");

    a_no_dev_init: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP)
        |=> !cfg_rdata[ppmc_pkg::PPMC_BIT_DSI])
        else $error("device init bit set");

    a_wake_clock_free: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP)
        |=> !cfg_rdata[ppmc_pkg::PPMC_BIT_CLK_WAKE])
        else $error("wake clock bit set");

    a_version_field: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP)
        |=> (cfg_rdata[ppmc_pkg::PPMC_VER_LSB +: 3]
             == ppmc_pkg::PPMC_VERSION))
        else $error("version field wrong");

    a_next_ptr_zero: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP)
        |=> (cfg_rdata[ppmc_pkg::PPMC_NEXT_LSB +: 8]
             == ppmc_pkg::PPMC_NEXT_PTR))
        else $error("next pointer not zero");

    a_capability_identifier_value: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset == ppmc_pkg::PPMC_OFF_CAP)
        |=> (cfg_rdata[7:0] == ppmc_pkg::PPMC_CAPABILITY_IDENTIFIER))
        else $error("capability identifier wrong");

    a_unmapped_zero: assert property (@(posedge clock)
        disable iff (!reset_n)
        (cfg_req.valid && !cfg_req.write
         && cfg_req.offset != ppmc_pkg::PPMC_OFF_CAP
         && cfg_req.offset != ppmc_pkg::PPMC_OFF_CAP_PTR)
        |=> (cfg_ack && cfg_rdata == 32'h0000_0000))
        else $error("unmapped read returned data");

    a_req_acked: assert property (@(posedge clock)
        disable iff (!reset_n)
        cfg_req.valid |=> cfg_ack)
        else $error("request not acknowledged next cycle");

    a_ack_single: assert property (@(posedge clock)
        disable iff (!reset_n)
        !cfg_req.valid |=> (!cfg_ack && cfg_rdata == 32'h0000_0000))
        else $error("ack or data without a request");
endmodule : ppmc_cap_reg
`default_nettype wire

//--- testbench/ppmc_host.sv
`timescale 1ns/1ps
`default_nettype none
module ppmc_host (
    input wire logic clock,
    output var ppmc_pkg::ppmc_req_t req,
    input wire logic ack,
    input wire logic [31:0] rdata
);
    initial req = '0;
    // one-cycle pulse, answer expected within four edges
    task automatic access(input logic wr, input logic [7:0] off,
                          output logic [31:0] d, output logic got);
        got = 1'b0;
        d = 32'h0;
        @(posedge clock);
        req <= {1'b1, wr, off, 4'hf};
        @(posedge clock);
        req <= '0;
        for (int n = 0; n < 4 && !got; n++) begin
            @(posedge clock);
            got = (ack === 1'b1);
            d = rdata;
        end
    endtask : access
endmodule : ppmc_host
`default_nettype wire

//--- testbench/pci_pm_capability_register_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module pci_pm_capability_register_bench;
    logic clock = 1'b0, reset_n = 1'b0, aux = 1'b0, got;
    logic [31:0] rdata, d;
    logic ack;
    ppmc_pkg::ppmc_req_t req;
    int err_total = 0, checked = 0, cycles = 0;
    ppmc_cap_reg dut_u (.clock(clock), .reset_n(reset_n), .cfg_req(req),
        .aux_supply_detect(aux), .cfg_rdata(rdata), .cfg_ack(ack));
    ppmc_host host_u (.clock(clock), .req(req), .ack(ack), .rdata(rdata));
    initial forever #12.5 clock = ~clock;
    function automatic logic [31:0] expv(input logic p);
        return {p, 1'b1, 2'b00, 1'b1, 2'b00, p ? 3'h6 : 3'h0, 3'b000,
                3'h2, 8'h00, 8'h01};
    endfunction : expv
    task automatic rd(input logic w, logic [7:0] off, logic [31:0] e);
        host_u.access(w, off, d, got);
        `CHK("ack", 1'b1, got)
        `CHK("rdata", e, d)
    endtask : rd
    task automatic t_low();
        aux <= 1'b0;
        repeat (3) @(posedge clock);
        rd(1'b0, 8'h78, expv(1'b0));
        $display("pin low done");
    endtask : t_low
    task automatic t_high();
        @(posedge clock);
        aux <= 1'b1;
        repeat (3) @(posedge clock);
        rd(1'b0, 8'h78, expv(1'b1));
        $display("pin high done");
    endtask : t_high
    task automatic t_write();
        rd(1'b1, 8'h78, 32'h0000_0000);
        rd(1'b0, 8'h78, expv(1'b1));
        $display("write done");
    endtask : t_write
    task automatic t_ptr();
        rd(1'b0, 8'h34, 32'h0000_0078);
        rd(1'b0, 8'h7c, 32'h0000_0000);
        $display("pointer done");
    endtask : t_ptr
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_low();
        t_high();
        t_write();
        t_ptr();
        t_low();
        wrap_up();
    end
endmodule : pci_pm_capability_register_bench
`default_nettype wire
